// [inc/ua_defs.vh]
// Function
// - holding byte loads shifter, sent lsb first
// - after last stop, reload and set empty
// - software write clears transmit empty flag
// - busy flag holds until stop and empty
// - async uses sixteen baud ticks per bit
// - start needs three low samples after seven
// - later bits decided by two-of-three vote
// - sample positions automatic unless manually selected
// - complete character copied, receive full set
// - reading receive buffer clears full flag
// - sync drives on rise, samples on fall
// - sync character ends after counted rising edges
// - sync clock external or driven from baud
// - attention uses nine bits, ninth marks address
// - attention discards until address character arrives
// - address character clears attention enable bit
// - ninth bit from control, reported in status
// - diagnostic loops transmitter into receiver, nine bits
// - seven bit frame with optional parity
// - eight bit frame with optional parity
// - nine bit frame select 2 uses no parity
// - parity in every format except frame select 2; frame select 3 gives nine bits and allows parity
// - baud from 5-bit prescaler, 11-bit divisor
`ifndef UA_DEFS_VH
`define UA_DEFS_VH

// register byte offsets
`define UA_A_TXBUF   8'h00
`define UA_A_RXBUF   8'h04
`define UA_A_STAT    8'h08
`define UA_A_FRS     8'h0C
`define UA_A_MDSL    8'h10
`define UA_A_MDSL2   8'h14
`define UA_A_SPOS    8'h18
`define UA_A_PSC     8'h1C
`define UA_A_DIV     8'h20

// frame select fields
`define UA_FMT_7     2'h0
`define UA_FMT_8     2'h1
`define UA_FMT_9     2'h2
`define UA_DW_7      4'h7
`define UA_DW_8      4'h8
`define UA_DW_9      4'h9

// reset values
`define UA_RST_FRS   6'h01
`define UA_RST_SPOS  4'h7
`define UA_AUTO_POS  4'h7

// timing
`define UA_PH_LAST   4'hF
`define UA_FRAME_W   13
`define UA_IDLE_FRM  13'h1FFF
`define UA_BUILD_INI 13'h1FFE

`endif

// [design/ua_core.v]
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ua_defs.vh"

module ua_core (
    input  wire        core_clk,
    input  wire        resetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        rxd,
    output reg         txd,
    input  wire        ckx_in,
    output reg         ckx_out,
    output reg         ckx_oe_n
);

    localparam RX_IDLE  = 3'b001;
    localparam RX_START = 3'b010;
    localparam RX_BITS  = 3'b100;

    // software registers
    reg  [7:0]  tx_holding_buffer_r;
    reg         tx_hold_full_r;
    reg  [7:0]  rx_holding_buffer_r;
    reg         rx_buffer_full_flag_r;
    reg         rx_ninth_bit_r;
    reg         parity_err_r;
    reg         frame_err_r;
    reg         overrun_r;
    reg  [1:0]  fmt_r;
    reg         stop2_r;
    reg         parity_enable_r;
    reg         odd_r;
    reg         tx_ninth_bit_r;
    reg         sync_r;
    reg         ckx_int_r;
    reg         attention_enable_r;
    reg         diag_r;
    reg         manual_sample_select_r;
    reg  [3:0]  sample_position_register_r;
    reg  [4:0]  baud_prescaler_r;
    reg  [10:0] baud_divisor_r;

    // baud generator
    reg  [5:0]  pre_acc_r;
    reg  [10:0] div_cnt_r;
    reg         tick_r;

    // pin synchronisers
    reg         rxd_s1_r;
    reg         rxd_s2_r;
    reg         ckx_s1_r;
    reg         ckx_s2_r;
    reg         ckx_s3_r;

    // transmitter
    reg  [12:0] tx_shift_register_r;
    reg  [3:0]  tx_cnt_r;
    reg  [3:0]  tx_ph_r;
    reg         tx_in_progress_flag_r;

    // receiver
    reg  [2:0]  rx_state_r;
    reg  [12:0] rx_shift_register_r;
    reg  [3:0]  rx_cnt_r;
    reg  [3:0]  rx_rise_r;
    reg  [3:0]  rx_ph_r;
    reg  [1:0]  vote_r;

    function [3:0] ua_dw;
        input [1:0] fmt;
        begin
            case (fmt)
                `UA_FMT_7: ua_dw = `UA_DW_7;
                `UA_FMT_8: ua_dw = `UA_DW_8;
                default:   ua_dw = `UA_DW_9;
            endcase
        end
    endfunction

    // total bits: start + data + parity + stops
    function [3:0] ua_flen;
        input [3:0] dw;
        input       pe;
        input       st2;
        begin
            ua_flen = dw + {3'h0, pe} + {3'h0, st2} + 4'h2;
        end
    endfunction

    function [12:0] ua_build;
        input [8:0] d;
        input [3:0] dw;
        input       pe;
        input       odd;
        integer     i;
        reg         p;
        begin
            ua_build = `UA_BUILD_INI;
            p = odd;
            for (i = 0; i < 9; i = i + 1) begin
                if (i < dw) begin
                    ua_build[i + 1] = d[i];
                    p = p ^ d[i];
                end
            end
            if (pe) begin
                ua_build[dw + 4'h1] = p;
            end
        end
    endfunction

    function ua_maj;
        input [2:0] s;
        begin
            ua_maj = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
        end
    endfunction

    // effective format: attention and diagnostic force nine bits, no parity
    wire        force9   = attention_enable_r | diag_r;
    wire [1:0]  fmt_eff  = force9 ? `UA_FMT_9 : fmt_r;
    wire [3:0]  dw       = ua_dw(fmt_eff);
    wire        pe_eff   = parity_enable_r & (fmt_eff != `UA_FMT_9);
    wire [3:0]  flen     = ua_flen(dw, pe_eff, stop2_r);
    wire [3:0]  rx_need  = flen - 4'h1;
    wire [8:0]  tx_word  = {tx_ninth_bit_r, tx_holding_buffer_r};
    wire [12:0] tx_frame = ua_build(tx_word, dw, pe_eff, odd_r);

    // serial clock edges, internal or external
    wire        ckx_drv   = sync_r & ckx_int_r;
    wire        rise      = ckx_drv ? (tick_r & ~ckx_out) : (ckx_s2_r & ~ckx_s3_r);
    wire        fall      = ckx_drv ? (tick_r & ckx_out) : (~ckx_s2_r & ckx_s3_r);
    wire        tx_adv    = sync_r ? rise : (tick_r & (tx_ph_r == `UA_PH_LAST));
    wire        tx_line   = tx_in_progress_flag_r ? tx_shift_register_r[0] : 1'b1;
    wire        rx_line   = diag_r ? tx_line : rxd_s2_r;

    // receive sample positions
    wire [3:0]  pos      = manual_sample_select_r ? sample_position_register_r
                                                  : `UA_AUTO_POS;
    wire        samp     = (rx_ph_r == pos) | (rx_ph_r == pos + 4'h1) | (rx_ph_r == pos + 4'h2);
    wire        decide   = rx_ph_r == pos + 4'h2;
    wire        bit_val  = ua_maj({vote_r, rx_line});

    // received character view
    // async completes on the last vote, so that bit is taken in before it lands
    wire [12:0] rx_word  = sync_r ? rx_shift_register_r
                                  : {bit_val, rx_shift_register_r[12:1]};
    wire [12:0] rx_align = rx_word >> (`UA_FRAME_W - rx_need);
    wire [8:0]  rx_data  = rx_align[8:0] & ~(9'h1FF << dw);
    wire        rx_par   = rx_align[dw];
    wire        rx_stop  = rx_align[dw + {3'h0, pe_eff}];
    wire        rx_pcalc = ^rx_data ^ odd_r;

    // bus access
    wire        setup    = psel & ~penable;
    wire        access   = psel & penable & pready;
    wire        wr       = access & pwrite;
    wire        rd       = access & ~pwrite;
    wire        tx_write = wr & (paddr == `UA_A_TXBUF);
    wire        rx_read  = rd & (paddr == `UA_A_RXBUF);
    wire        st_read  = rd & (paddr == `UA_A_STAT);
    wire        md_write = wr & (paddr == `UA_A_MDSL);

    reg  [31:0] rd_val;
    reg         hit;
    always @* begin
        rd_val = 32'h0;
        hit    = 1'b1;
        case (paddr)
            `UA_A_TXBUF: rd_val = {24'h0, tx_holding_buffer_r};
            `UA_A_RXBUF: rd_val = {24'h0, rx_holding_buffer_r};
            `UA_A_STAT:  rd_val = {25'h0, overrun_r, frame_err_r, parity_err_r,
                                   rx_ninth_bit_r, tx_in_progress_flag_r,
                                   rx_buffer_full_flag_r, ~tx_hold_full_r};
            `UA_A_FRS:   rd_val = {26'h0, tx_ninth_bit_r, odd_r, parity_enable_r,
                                   stop2_r, fmt_r};
            `UA_A_MDSL:  rd_val = {28'h0, diag_r, attention_enable_r, ckx_int_r, sync_r};
            `UA_A_MDSL2: rd_val = {31'h0, manual_sample_select_r};
            `UA_A_SPOS:  rd_val = {28'h0, sample_position_register_r};
            `UA_A_PSC:   rd_val = {27'h0, baud_prescaler_r};
            `UA_A_DIV:   rd_val = {21'h0, baud_divisor_r};
            default:     hit    = 1'b0;
        endcase
    end

    // apb slave: no wait states, answer registered in the setup cycle
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0 : rd_val;
            pready  <= 1'b1;
            pslverr <= ~hit;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // configuration registers
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fmt_r                      <= `UA_FMT_8;
            stop2_r                    <= 1'b0;
            parity_enable_r            <= 1'b0;
            odd_r                      <= 1'b0;
            tx_ninth_bit_r             <= 1'b0;
            sync_r                     <= 1'b0;
            ckx_int_r                  <= 1'b0;
            diag_r                     <= 1'b0;
            manual_sample_select_r     <= 1'b0;
            sample_position_register_r <= `UA_RST_SPOS;
            baud_prescaler_r           <= 5'h00;
            baud_divisor_r             <= 11'h000;
        end else if (wr) begin
            case (paddr)
                `UA_A_FRS: begin
                    fmt_r           <= pwdata[1:0];
                    stop2_r         <= pwdata[2];
                    parity_enable_r <= pwdata[3];
                    odd_r           <= pwdata[4];
                    tx_ninth_bit_r  <= pwdata[5];
                end
                `UA_A_MDSL: begin
                    sync_r    <= pwdata[0];
                    ckx_int_r <= pwdata[1];
                    diag_r    <= pwdata[3];
                end
                `UA_A_MDSL2: manual_sample_select_r     <= pwdata[0];
                `UA_A_SPOS:  sample_position_register_r <= pwdata[3:0];
                `UA_A_PSC:   baud_prescaler_r           <= pwdata[4:0];
                `UA_A_DIV:   baud_divisor_r             <= pwdata[10:0];
                default: ;
            endcase
        end
    end

    // baud generator: half-step prescaler, then divisor
    wire [5:0] pre_lim  = {1'b0, baud_prescaler_r} + 6'h01;
    wire [5:0] pre_next = pre_acc_r + 6'h02;
    wire       pre_tick = (baud_prescaler_r != 5'h00) & (pre_next >= pre_lim);
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pre_acc_r <= 6'h00;
            div_cnt_r <= 11'h000;
            tick_r    <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (baud_prescaler_r == 5'h00) begin
                pre_acc_r <= 6'h00;
                div_cnt_r <= 11'h000;
            end else if (pre_tick) begin
                pre_acc_r <= pre_next - pre_lim;
                if (div_cnt_r == baud_divisor_r) begin
                    div_cnt_r <= 11'h000;
                    tick_r    <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 11'h001;
                end
            end else begin
                pre_acc_r <= pre_next;
            end
        end
    end

    // pin synchronisers and serial clock pin
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rxd_s1_r <= 1'b1;
            rxd_s2_r <= 1'b1;
            ckx_s1_r <= 1'b1;
            ckx_s2_r <= 1'b1;
            ckx_s3_r <= 1'b1;
            ckx_out  <= 1'b1;
            ckx_oe_n <= 1'b1;
            txd      <= 1'b1;
        end else begin
            rxd_s1_r <= rxd;
            rxd_s2_r <= rxd_s1_r;
            ckx_s1_r <= ckx_in;
            ckx_s2_r <= ckx_s1_r;
            ckx_s3_r <= ckx_s2_r;
            ckx_oe_n <= ~ckx_drv;
            if (!ckx_drv) begin
                ckx_out <= 1'b1;
            end else if (tick_r) begin
                ckx_out <= ~ckx_out;
            end
            txd <= diag_r ? 1'b1 : tx_line;
        end
    end

    // transmit holding buffer and empty flag
    wire tx_load = tx_hold_full_r & ((~tx_in_progress_flag_r & (~sync_r | rise)) |
                   (tx_in_progress_flag_r & tx_adv & (tx_cnt_r == 4'h1)));
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tx_holding_buffer_r <= 8'h00;
            tx_hold_full_r      <= 1'b0;
        end else begin
            if (tx_write) begin
                tx_holding_buffer_r <= pwdata[7:0];
                tx_hold_full_r      <= 1'b1;
            end else if (tx_load) begin
                tx_hold_full_r      <= 1'b0;
            end
        end
    end

    // transmit shifter
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tx_shift_register_r   <= `UA_IDLE_FRM;
            tx_cnt_r              <= 4'h0;
            tx_ph_r               <= 4'h0;
            tx_in_progress_flag_r <= 1'b0;
        end else begin
            if (tick_r) begin
                tx_ph_r <= tx_ph_r + 4'h1;
            end
            if (tx_load) begin
                tx_shift_register_r   <= tx_frame;
                tx_cnt_r              <= flen;
                tx_ph_r               <= 4'h0;
                tx_in_progress_flag_r <= 1'b1;
            end else if (tx_in_progress_flag_r & tx_adv) begin
                if (tx_cnt_r == 4'h1) begin
                    tx_in_progress_flag_r <= 1'b0;
                    tx_shift_register_r   <= `UA_IDLE_FRM;
                end else begin
                    tx_shift_register_r <= {1'b1, tx_shift_register_r[12:1]};
                    tx_cnt_r            <= tx_cnt_r - 4'h1;
                end
            end
        end
    end

    // receiver sequencing
    wire rx_done_a = ~sync_r & tick_r & (rx_state_r == RX_BITS) & decide & (rx_cnt_r == 4'h1);
    wire rx_done_s = sync_r & rise & (rx_state_r == RX_BITS) & (rx_rise_r + 4'h1 == flen);
    wire rx_done   = rx_done_a | rx_done_s;
    wire rx_shift  = (~sync_r & tick_r & (rx_state_r == RX_BITS) & decide) |
                     (sync_r & fall & (rx_state_r == RX_BITS) & (rx_cnt_r != 4'h0));

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rx_state_r          <= RX_IDLE;
            rx_shift_register_r <= 13'h0000;
            rx_cnt_r            <= 4'h0;
            rx_rise_r           <= 4'h0;
            rx_ph_r             <= 4'h0;
            vote_r              <= 2'h3;
        end else begin
            if (rx_shift) begin
                rx_shift_register_r <= {sync_r ? rx_line : bit_val,
                                        rx_shift_register_r[12:1]};
                rx_cnt_r            <= rx_cnt_r - 4'h1;
            end
            if (~sync_r & tick_r & samp) begin
                vote_r <= {vote_r[0], rx_line};
            end
            if (~sync_r & tick_r) begin
                rx_ph_r <= rx_ph_r + 4'h1;
            end
            case (rx_state_r)
                RX_IDLE: begin
                    rx_rise_r <= 4'h0;
                    rx_cnt_r  <= rx_need;
                    if (~sync_r & tick_r & ~rx_line) begin
                        rx_ph_r    <= 4'h1;
                        rx_state_r <= RX_START;
                    end else if (sync_r & fall & ~rx_line) begin
                        rx_state_r <= RX_BITS;
                    end
                end
                RX_START: begin
                    if (sync_r) begin
                        rx_state_r <= RX_IDLE;
                    end else if (tick_r & decide) begin
                        if (~vote_r[1] & ~vote_r[0] & ~rx_line) begin
                            rx_state_r <= RX_BITS;
                        end else begin
                            rx_state_r <= RX_IDLE;
                        end
                    end
                end
                RX_BITS: begin
                    if (sync_r & rise) begin
                        rx_rise_r <= rx_rise_r + 4'h1;
                    end
                    if (rx_done) begin
                        rx_state_r <= RX_IDLE;
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    // character completion: buffer, flags, attention filter
    wire rx_accept = rx_done & (~attention_enable_r | rx_data[8]);
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rx_holding_buffer_r   <= 8'h00;
            rx_buffer_full_flag_r <= 1'b0;
            rx_ninth_bit_r        <= 1'b0;
            parity_err_r          <= 1'b0;
            frame_err_r           <= 1'b0;
            overrun_r             <= 1'b0;
            attention_enable_r    <= 1'b0;
        end else begin
            if (rx_accept) begin
                rx_holding_buffer_r   <= rx_data[7:0];
                rx_ninth_bit_r        <= rx_data[8];
                rx_buffer_full_flag_r <= 1'b1;
            end else if (rx_read) begin
                rx_buffer_full_flag_r <= 1'b0;
            end
            if (rx_accept & pe_eff & (rx_par != rx_pcalc)) begin
                parity_err_r <= 1'b1;
            end else if (st_read) begin
                parity_err_r <= 1'b0;
            end
            if (rx_accept & ~rx_stop) begin
                frame_err_r <= 1'b1;
            end else if (st_read) begin
                frame_err_r <= 1'b0;
            end
            if (rx_accept & rx_buffer_full_flag_r & ~rx_read) begin
                overrun_r <= 1'b1;
            end else if (st_read) begin
                overrun_r <= 1'b0;
            end
            if (md_write) begin
                attention_enable_r <= pwdata[2];
            end else if (rx_accept & attention_enable_r) begin
                attention_enable_r <= 1'b0;
            end
        end
    end

endmodule // ua_core

// [tb/ua_asserts.sv]
`timescale 1ns/1ps
`include "ua_defs.vh"
module ua_chk (
    input wire        core_clk,
    input wire        resetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        txd,
    input wire        ckx_out,
    input wire        ckx_oe_n
);
    logic [3:0] mode_r;
    logic       psc1_r;
    logic       div0_r;
    logic [7:0] lo_r;
    logic [7:0] hi_r;
    wire        wr_ok = psel && penable && pready && pwrite && !pslverr;
    // async framing with one uart clock per baud tick
    wire        fast = psc1_r && div0_r && !mode_r[0] && !mode_r[3];
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= 4'h0;
            psc1_r <= 1'b0;
            div0_r <= 1'b1;
            lo_r   <= 8'h00;
            hi_r   <= 8'h00;
        end else begin
            if (wr_ok && paddr == `UA_A_MDSL)
                mode_r <= pwdata[3:0];
            if (wr_ok && paddr == `UA_A_PSC)
                psc1_r <= pwdata[4:0] == 5'h01;
            if (wr_ok && paddr == `UA_A_DIV)
                div0_r <= pwdata[10:0] == 11'h000;
            lo_r <= txd ? 8'h00 : lo_r + 8'h01;
            hi_r <= !txd ? 8'h00 : (hi_r == 8'hFF ? hi_r : hi_r + 8'h01);
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    AST_SLVERR_RDY: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    AST_RDY_ONE: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");
    AST_UNMAP_ZERO: assert property (pready && paddr > `UA_A_DIV |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_CKX_DRV: assert property (wr_ok && paddr == `UA_A_MDSL |->
        ##2 ckx_oe_n == ($past(pwdata[1:0], 2) != 2'h3))
        else $error("clock pin drive wrong");
    AST_CKX_IDLE: assert property (ckx_oe_n |-> ckx_out)
        else $error("clock output not high while released");
    AST_DIAG_HIGH: assert property (mode_r[3] |-> txd)
        else $error("line not high in loop mode");
    AST_BIT16: assert property ($rose(txd) && fast |-> lo_r[3:0] == 4'h0)
        else $error("low run not whole bit times");
    AST_START_WR: assert property (wr_ok && paddr == `UA_A_TXBUF && fast && hi_r == 8'hFF
        |-> ##[1:4] !txd)
        else $error("start bit missing after write");
endmodule // ua_chk
bind ua_core ua_chk chk_u (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .txd, .ckx_out, .ckx_oe_n);

// [tb/ua_remote.sv]
`timescale 1ns/1ps
module ua_remote (
    input  wire  core_clk,
    input  wire  txd,
    input  wire  serial_clock_pin,
    output logic rxd
);
    initial rxd = 1'b1;
    // frame with start, n bits lsb first, one stop; bit 3 may be disturbed
    task automatic send(input logic [8:0] d, input int n, input int gp, input int gl);
        for (int i = 0; i <= n + 1; i++) begin
            for (int p = 0; p < 16; p++) begin
                @(posedge core_clk);
                rxd <= (i == 0 ? 1'b0 : i > n ? 1'b1 : d[i-1]) ^ (i == 4 && p >= gp && p < gp + gl);
            end
        end
    endtask
    task automatic blip;
        @(posedge core_clk);
        rxd <= 1'b0;
        repeat (3) @(posedge core_clk);
        rxd <= 1'b1;
    endtask
    task automatic grab(input int n, output logic [11:0] b);
        b = 12'h000;
        while (txd !== 1'b0) @(posedge core_clk);
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            repeat (16) @(posedge core_clk);
            b[i] = txd;
        end
    endtask
    task automatic sgrab(input int n, output logic [11:0] b);
        logic q;
        int   i;
        b = 12'h000;
        q = 1'b1;
        i = -1;
        while (i < n) begin
            @(posedge core_clk);
            if (q && !serial_clock_pin) begin
                if (i >= 0)
                    b[i] = txd;
                if (i >= 0 || txd === 1'b0)
                    i++;
            end
            q = serial_clock_pin;
        end
    endtask
endmodule // ua_remote

// [tb/test_uart_async_sync_core.sv]
`timescale 1ns/1ps
`include "ua_defs.vh"
module test_uart_async_sync_core;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, txd, rxd, ckx_out, ckx_oe_n;
    wire         serial_clock_pin = ckx_oe_n ? 1'b1 : ckx_out;
    int          n_errors = 0;
    int          total_checks = 0;
    int          cyc = 0;
    logic [31:0] rdat;
    logic        err;
    logic [11:0] b;
    logic [7:0]  fr [0:3] = '{8'h08, 8'h18, 8'h0D, 8'h2A};
    logic [7:0]  dt [0:3] = '{8'hD5, 8'h55, 8'h01, 8'hC3};
    logic [11:0] ex [0:3] = '{12'h155, 12'h1D5, 12'h701, 12'h3C3};
    int          nb [0:3] = '{9, 9, 11, 10};
    always #5 core_clk = ~core_clk;
    ua_core dut_u (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rxd, .txd, .ckx_in(serial_clock_pin), .ckx_out, .ckx_oe_n);
    ua_remote remote_u (.core_clk, .txd, .serial_clock_pin, .rxd);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(rdat & m, e);
    endtask
    task idle;
        repeat (300) @(posedge core_clk);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            give_verdict;
        end
    end
    initial begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        rdc(`UA_A_FRS, 32'h01, 32'h3F);
        rdc(`UA_A_SPOS, 32'h7, 32'hF);
        rdc(`UA_A_STAT, 32'h1, 32'h7);
        apb(1'b0, 8'h24, 32'h0);
        chk({rdat[31:1], err}, 32'h1);
        wr(`UA_A_PSC, 32'h01);
        wr(`UA_A_DIV, 32'h0);
        idle;
        $display("test reset done");
        fork
            begin
                remote_u.grab(9, b);
                chk(b, 12'h1A5);
                remote_u.grab(9, b);
                chk(b, 12'h13C);
            end
            begin
                wr(`UA_A_TXBUF, 32'hA5);
                wr(`UA_A_TXBUF, 32'h3C);
                rdc(`UA_A_STAT, 32'h4, 32'h5);
            end
        join
        repeat (24) @(posedge core_clk);
        rdc(`UA_A_STAT, 32'h1, 32'h5);
        $display("test transmit done");
        for (int j = 0; j < 2; j++) begin
            wr(`UA_A_MDSL2, j);
            wr(`UA_A_SPOS, 32'h2);
            remote_u.blip;
            repeat (20) @(posedge core_clk);
            remote_u.send(9'h05A, 8, 3, 2);
            rdc(`UA_A_STAT, 32'h2, 32'h2);
            rdc(`UA_A_RXBUF, j ? 32'h52 : 32'h5A, 32'hFF);
            rdc(`UA_A_STAT, 32'h0, 32'h2);
        end
        wr(`UA_A_MDSL2, 32'h0);
        $display("test receive done");
        for (int i = 0; i < 4; i++) begin
            wr(`UA_A_FRS, fr[i]);
            fork
                remote_u.grab(nb[i], b);
                wr(`UA_A_TXBUF, dt[i]);
            join
            chk(b, ex[i]);
            idle;
        end
        $display("test formats done");
        wr(`UA_A_FRS, 32'h02);
        wr(`UA_A_MDSL, 32'h4);
        remote_u.send(9'h011, 9, 99, 0);
        rdc(`UA_A_STAT, 32'h0, 32'h2);
        remote_u.send(9'h142, 9, 99, 0);
        rdc(`UA_A_STAT, 32'hA, 32'hA);
        rdc(`UA_A_MDSL, 32'h0, 32'h4);
        rdc(`UA_A_RXBUF, 32'h42, 32'hFF);
        remote_u.send(9'h033, 9, 99, 0);
        rdc(`UA_A_STAT, 32'h2, 32'hA);
        rdc(`UA_A_RXBUF, 32'h33, 32'hFF);
        $display("test attention done");
        wr(`UA_A_FRS, 32'h20);
        wr(`UA_A_MDSL, 32'h8);
        wr(`UA_A_TXBUF, 32'h96);
        idle;
        rdc(`UA_A_STAT, 32'hA, 32'hA);
        rdc(`UA_A_RXBUF, 32'h96, 32'hFF);
        wr(`UA_A_MDSL, 32'h0);
        idle;
        $display("test loop done");
        wr(`UA_A_FRS, 32'h01);
        wr(`UA_A_MDSL, 32'h3);
        fork
            remote_u.sgrab(9, b);
            wr(`UA_A_TXBUF, 32'h6B);
        join
        chk(b, 12'h16B);
        chk(ckx_oe_n, 1'b0);
        idle;
        wr(`UA_A_MDSL, 32'hB);
        wr(`UA_A_TXBUF, 32'hC6);
        idle;
        rdc(`UA_A_STAT, 32'h2, 32'hA);
        rdc(`UA_A_RXBUF, 32'hC6, 32'hFF);
        wr(`UA_A_MDSL, 32'h0);
        idle;
        $display("test sync done");
        give_verdict;
    end
endmodule // test_uart_async_sync_core
